// ==== cbsu_pkg.sv ====
// constants and types for the conditional branch and skip unit
// assumes: compiled before cbsu_top; 32-bit APB data, byte addresses
package cbsu_pkg;

    // ========================================
    // register map
    localparam logic [7:0] CBSU_CMD_OFS = 8'h00;
    localparam logic [7:0] CBSU_OFFS_OFS = 8'h04;
    localparam logic [7:0] CBSU_PC_OFS = 8'h08;
    localparam logic [7:0] CBSU_FLAGS_OFS = 8'h0c;
    localparam logic [7:0] CBSU_IO_OFS = 8'h10;
    localparam logic [7:0] CBSU_STAT_OFS = 8'h14;

    // ========================================
    // field positions
    localparam int CBSU_CMD_OP_LSB = 0;
    localparam int CBSU_CMD_SEL_LSB = 8;
    localparam int CBSU_CMD_TWO_BIT = 12;
    localparam int CBSU_STAT_BUSY_BIT = 0;
    localparam int CBSU_STAT_TAKEN_BIT = 1;
    localparam int CBSU_STAT_CYC_LSB = 4;

    // condition flag positions
    localparam int CBSU_F_C = 0;
    localparam int CBSU_F_Z = 1;
    localparam int CBSU_F_N = 2;
    localparam int CBSU_F_V = 3;
    localparam int CBSU_F_S = 4;
    localparam int CBSU_F_H = 5;
    localparam int CBSU_F_T = 6;
    localparam int CBSU_F_I = 7;

    // ========================================
    // widths and reset values
    localparam int CBSU_PC_W = 16;
    localparam int CBSU_K_W = 7;
    localparam logic [15:0] CBSU_PC_RST = 16'h0000;
    localparam logic [7:0] CBSU_FLAGS_RST = 8'h00;
    localparam logic [7:0] CBSU_IO_RST = 8'h00;
    localparam logic [6:0] CBSU_K_RST = 7'h00;

    // ========================================
    // cycle counts
    localparam logic [1:0] CBSU_CYC_FALL = 2'h1;
    localparam logic [1:0] CBSU_CYC_TAKEN = 2'h2;
    localparam logic [1:0] CBSU_CYC_SKIP1 = 2'h2;
    localparam logic [1:0] CBSU_CYC_SKIP2 = 2'h3;

    typedef enum logic [4:0] {
        OP_SKIP_ON, OP_SKIP_OFF, OP_FLAG_ON, OP_FLAG_OFF,
        OP_EQ, OP_NE, OP_CS, OP_CC, OP_SH, OP_LO,
        OP_MI, OP_PL, OP_GE, OP_LT, OP_HS, OP_HC,
        OP_TS, OP_TC, OP_VS, OP_VC, OP_IE
    } cbsu_op_t;

    typedef enum logic {ST_IDLE, ST_EXEC} cbsu_state_t;

endpackage

// ==== cbsu_tb.sv ====
// self-checking testbench for the conditional branch and skip unit
// assumes: cbsu_pkg and cbsu_top compiled first; one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end

module tb
    import cbsu_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, busy_o, taken_o, done_o;
    logic [15:0] pc_o;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'hb;
    logic [31:0] r, r2;
    logic [7:0] f, io;
    logic [6:0] k;
    logic [2:0] s;
    logic two;
    int busy_cyc = 0;
    int n_done = 0;

    always #2 pclk = ~pclk;

    // busy cycles and done pulses as seen at each rising edge
    always @(posedge pclk) begin
        if (busy_o === 1'b1) busy_cyc <= busy_cyc + 1;
        if (done_o === 1'b1) n_done <= n_done + 1;
    end

    cbsu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_o(pc_o),
        .busy_o(busy_o), .taken_o(taken_o), .done_o(done_o));

    // ========================================
    // reference functions
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic cond(input logic [4:0] op, input logic [2:0] b,
        input logic [7:0] fl, input logic [7:0] iob);
        case (op)
            5'd0: return iob[b];
            5'd1: return !iob[b];
            5'd2: return fl[b];
            5'd3: return !fl[b];
            5'd4: return fl[CBSU_F_Z];
            5'd5: return !fl[CBSU_F_Z];
            5'd6: return fl[CBSU_F_C];
            5'd7: return !fl[CBSU_F_C];
            5'd8: return !fl[CBSU_F_C];
            5'd9: return fl[CBSU_F_C];
            5'd10: return fl[CBSU_F_N];
            5'd11: return !fl[CBSU_F_N];
            5'd12: return !(fl[CBSU_F_N] ^ fl[CBSU_F_V]);
            5'd13: return fl[CBSU_F_N] ^ fl[CBSU_F_V];
            5'd14: return fl[CBSU_F_H];
            5'd15: return !fl[CBSU_F_H];
            5'd16: return fl[CBSU_F_T];
            5'd17: return !fl[CBSU_F_T];
            5'd18: return fl[CBSU_F_V];
            5'd19: return !fl[CBSU_F_V];
            5'd20: return fl[CBSU_F_I];
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] ncyc(input logic t, input logic [4:0] op,
        input logic tw);
        if (!t) return 2'd1;
        if (op < 5'd2) return tw ? 2'd3 : 2'd2;
        return 2'd2;
    endfunction

    function automatic logic [15:0] npc(input logic t, input logic [4:0] op,
        input logic tw, input logic [6:0] kk, input logic [15:0] p);
        if (!t) return p + 16'h1;
        if (op < 5'd2) return p + 16'h2 + {15'h0, tw};
        return p + {{9{kk[6]}}, kk} + 16'h1;
    endfunction

    // ========================================
    // bus tasks
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int w;
        w = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the completing edge
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        if (w >= 50) begin
            errors++;
            $display("ERROR pready expected 1 seen timeout");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call drives each signal only once
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic ee);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
        `CHK("write error", ee, e)
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
        input logic ee, input string nm);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        `CHK("read error", ee, e)
        `CHK(nm, exp, rd)
    endtask

    // one instruction; intrude tries a write while it runs
    task automatic run(input logic [4:0] op, input logic [2:0] b,
        input logic tw, input logic [7:0] fl, input logic [7:0] iob,
        input logic [6:0] kk, input logic [15:0] p, input logic intrude);
        logic [31:0] cmd;
        logic t;
        int c, g, d;
        cmd = 32'h0;
        cmd[4:0] = op;
        cmd[10:8] = b;
        cmd[12] = tw;
        c = busy_cyc;
        d = n_done;
        g = 0;
        t = cond(op, b, fl, iob);
        wr(CBSU_PC_OFS, {16'h0, p}, 1'b0);
        wr(CBSU_OFFS_OFS, {25'h0, kk}, 1'b0);
        wr(CBSU_FLAGS_OFS, {24'h0, fl}, 1'b0);
        wr(CBSU_IO_OFS, {24'h0, iob}, 1'b0);
        wr(CBSU_CMD_OFS, cmd, 1'b0);
        if (intrude) wr(CBSU_PC_OFS, 32'h1234, 1'b1);
        while (n_done == d && g < 20) begin
            @(posedge pclk);
            g++;
        end
        if (g >= 20) begin
            errors++;
            $display("ERROR done expected pulse seen timeout");
        end
        `CHK("cycles", int'(ncyc(t, op, tw)), busy_cyc - c)
        `CHK("done pulses", 1, n_done - d)
        `CHK("pc", npc(t, op, tw, kk, p), pc_o)
        `CHK("taken", t, taken_o)
        rdchk(CBSU_STAT_OFS, {26'h0, ncyc(t, op, tw), 2'b00, t, 1'b0},
            1'b0, "status");
        rdchk(CBSU_FLAGS_OFS, {24'h0, fl}, 1'b0, "flags");
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (9) @(posedge pclk);
        @(negedge pclk);
        `CHK("reset bus", 34'h0, {prdata, pready, pslverr})
        `CHK("reset core", 19'h0, {pc_o, busy_o, taken_o, done_o})
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        `CHK("reset outputs", 19'h0, {pc_o, busy_o, taken_o, done_o})
        @(posedge pclk);
        rdchk(CBSU_PC_OFS, 32'h0, 1'b0, "pc reset");
        rdchk(CBSU_OFFS_OFS, 32'h0, 1'b0, "offset reset");
        rdchk(CBSU_FLAGS_OFS, 32'h0, 1'b0, "flags reset");
        rdchk(CBSU_IO_OFS, 32'h0, 1'b0, "io reset");
        rdchk(CBSU_STAT_OFS, 32'h0, 1'b0, "status reset");
        $display("test reset done");
        for (int i = 0; i < 126; i++) begin
            r = xorshift();
            r2 = xorshift();
            f = r[7:0];
            io = r[15:8];
            k = r[22:16];
            s = r[25:23];
            two = r[26];
            if (i < 42) begin
                f = (i < 21) ? 8'h00 : 8'hff;
                io = f;
            end
            if (i >= 105) begin
                k = i[0] ? 7'h40 : 7'h3f;
                r2[15:0] = 16'hffff;
            end
            run(5'(i % 21), s, two, f, io, k, r2[15:0], 1'b0);
        end
        $display("test instructions done");
        wr(CBSU_CMD_OFS, 32'h15, 1'b1);
        @(negedge pclk);
        `CHK("busy after bad op", 1'b0, busy_o)
        @(posedge pclk);
        wr(CBSU_STAT_OFS, 32'h0, 1'b1);
        rdchk(8'h18, 32'h0, 1'b1, "unmapped");
        run(5'd0, 3'd0, 1'b1, 8'h00, 8'h01, 7'h05, 16'h0100, 1'b1);
        run(5'd1, 3'd7, 1'b1, 8'h00, 8'h7f, 7'h05, 16'h0200, 1'b1);
        $display("test refusals done");
        presetn <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        `CHK("mid reset", 19'h0, {pc_o, busy_o, taken_o, done_o})
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        `CHK("after reset", 16'h0, pc_o)
        @(posedge pclk);
        rdchk(CBSU_IO_OFS, 32'h0, 1'b0, "io mid reset");
        run(5'd13, 3'd0, 1'b0, 8'h08, 8'h00, 7'h7f, 16'h0010, 1'b0);
        $display("test mid reset done");
        conclude();
    end

    initial begin
        #(4 * 20000);
        errors++;
        $display("ERROR watchdog expected end seen hang");
        conclude();
    end
endmodule // tb
`default_nettype wire

// ==== cbsu_top.sv ====
// conditional branch and skip unit with APB register access
// assumes: APB master on pclk; flags and I/O byte loaded by software
//
// Overview of operation
// - skip_io_bit_on skips when io bit is one
// - branch_flag_on branches when indexed flag set
// - branch_flag_off branches when indexed flag clear
// - equal on Z one, unequal on Z zero
// - carry_on on C one, carry_off on zero
// - unsigned_ge on C zero, lt on one
// - negative on N one, nonnegative on zero
// - signed_ge when N xor V zero
// - signed_lt when N xor V one
// - halfcarry_on on H one, off on zero
// - userbit_on on T one, off on zero
// - overflow_on on V one, off on zero
// - irq_enabled branches when I flag set
// - skip_io_bit_off skips when io bit zero
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module cbsu_top
    import cbsu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] pc_o,
    output logic busy_o,
    output logic taken_o,
    output logic done_o
);

    // ========================================
    // decode helpers
    function automatic logic op_legal(input logic [4:0] code);
        return code <= OP_IE;
    endfunction

    function automatic logic op_skip(input cbsu_op_t op);
        return (op == OP_SKIP_ON) || (op == OP_SKIP_OFF);
    endfunction

    function automatic logic cond_of(
        input cbsu_op_t op,
        input logic [7:0] f,
        input logic [2:0] s,
        input logic [7:0] io
    );
        unique case (op)
            OP_SKIP_ON: return io[s];
            OP_SKIP_OFF: return !io[s];
            OP_FLAG_ON: return f[s];
            OP_FLAG_OFF: return !f[s];
            OP_EQ: return f[CBSU_F_Z];
            OP_NE: return !f[CBSU_F_Z];
            OP_CS: return f[CBSU_F_C];
            OP_CC: return !f[CBSU_F_C];
            OP_SH: return !f[CBSU_F_C];
            OP_LO: return f[CBSU_F_C];
            OP_MI: return f[CBSU_F_N];
            OP_PL: return !f[CBSU_F_N];
            OP_GE: return !(f[CBSU_F_N] ^ f[CBSU_F_V]);
            OP_LT: return f[CBSU_F_N] ^ f[CBSU_F_V];
            OP_HS: return f[CBSU_F_H];
            OP_HC: return !f[CBSU_F_H];
            OP_TS: return f[CBSU_F_T];
            OP_TC: return !f[CBSU_F_T];
            OP_VS: return f[CBSU_F_V];
            OP_VC: return !f[CBSU_F_V];
            OP_IE: return f[CBSU_F_I];
            default: return 1'b0;
        endcase
    endfunction

    // ========================================
    // state
    cbsu_state_t state_q;
    cbsu_op_t op_q;
    logic [2:0] sel_q;
    logic two_q;
    logic [6:0] k_q;
    logic [15:0] pc_q;
    logic [15:0] tgt_q;
    logic [7:0] flags_q;
    logic [7:0] io_q;
    logic [1:0] cnt_q;
    logic [1:0] cyc_q;
    logic taken_q;
    logic done_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // ========================================
    // APB slave
    logic access;
    logic wr_fire;
    logic mapped;
    logic busy;
    logic cmd_bad;
    logic refuse;
    logic start;
    logic [31:0] rd_d;
    cbsu_op_t new_op;
    logic [2:0] new_sel;
    logic new_two;
    logic new_cond;
    logic [1:0] new_cyc;
    logic [15:0] br_tgt;

    assign access = psel && penable && pready_q;
    // the refusal latched with pslverr gates the commit, so reply and effect agree
    assign wr_fire = access && pwrite && !pslverr_q;
    assign busy = (state_q == ST_EXEC);
    assign mapped = (paddr == CBSU_CMD_OFS) || (paddr == CBSU_OFFS_OFS)
        || (paddr == CBSU_PC_OFS) || (paddr == CBSU_FLAGS_OFS)
        || (paddr == CBSU_IO_OFS) || (paddr == CBSU_STAT_OFS);
    assign cmd_bad = (paddr == CBSU_CMD_OFS)
        && !op_legal(pwdata[CBSU_CMD_OP_LSB +: 5]);
    // writes during execution are refused so flags stay put
    assign refuse = !mapped || (pwrite && (busy || cmd_bad
        || paddr == CBSU_STAT_OFS));
    assign start = wr_fire && (paddr == CBSU_CMD_OFS);

    assign new_op = cbsu_op_t'(pwdata[CBSU_CMD_OP_LSB +: 5]);
    assign new_sel = pwdata[CBSU_CMD_SEL_LSB +: 3];
    assign new_two = pwdata[CBSU_CMD_TWO_BIT];
    assign new_cond = cond_of(new_op, flags_q, new_sel, io_q);

    // target uses k as a signed offset
    assign br_tgt = pc_q + {{(CBSU_PC_W - CBSU_K_W){k_q[6]}}, k_q}
        + 16'h0001;

    always_comb begin
        if (!new_cond) begin
            new_cyc = CBSU_CYC_FALL;
        end else if (!op_skip(new_op)) begin
            new_cyc = CBSU_CYC_TAKEN;
        end else if (new_two) begin
            new_cyc = CBSU_CYC_SKIP2;
        end else begin
            new_cyc = CBSU_CYC_SKIP1;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            CBSU_CMD_OFS: begin
                rd_d[CBSU_CMD_OP_LSB +: 5] = op_q;
                rd_d[CBSU_CMD_SEL_LSB +: 3] = sel_q;
                rd_d[CBSU_CMD_TWO_BIT] = two_q;
            end
            CBSU_OFFS_OFS: rd_d[6:0] = k_q;
            CBSU_PC_OFS: rd_d[15:0] = pc_q;
            CBSU_FLAGS_OFS: rd_d[7:0] = flags_q;
            CBSU_IO_OFS: rd_d[7:0] = io_q;
            CBSU_STAT_OFS: begin
                rd_d[CBSU_STAT_BUSY_BIT] = busy;
                rd_d[CBSU_STAT_TAKEN_BIT] = taken_q;
                rd_d[CBSU_STAT_CYC_LSB +: 2] = cyc_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // one wait state: ready rises on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && refuse;
            if (psel && penable && !pready_q && !pwrite) begin
                prdata_q <= rd_d;
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ========================================
    // software-loaded operands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= CBSU_FLAGS_RST;
            io_q <= CBSU_IO_RST;
            k_q <= CBSU_K_RST;
        end else if (wr_fire) begin
            if (paddr == CBSU_FLAGS_OFS) begin
                flags_q <= pwdata[7:0];
            end
            if (paddr == CBSU_IO_OFS) begin
                io_q <= pwdata[7:0];
            end
            if (paddr == CBSU_OFFS_OFS) begin
                k_q <= pwdata[6:0];
            end
        end
    end

    // ========================================
    // instruction sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            op_q <= OP_SKIP_ON;
            sel_q <= 3'h0;
            two_q <= 1'b0;
            cnt_q <= 2'h0;
            cyc_q <= 2'h0;
            taken_q <= 1'b0;
            tgt_q <= CBSU_PC_RST;
        end else if (start) begin
            state_q <= ST_EXEC;
            op_q <= new_op;
            sel_q <= new_sel;
            two_q <= new_two;
            cnt_q <= new_cyc;
            cyc_q <= new_cyc;
            taken_q <= new_cond;
            if (!new_cond) begin
                tgt_q <= pc_q + 16'h0001;
            end else if (op_skip(new_op)) begin
                tgt_q <= pc_q + {14'h0000, new_cyc};
            end else begin
                tgt_q <= br_tgt;
            end
        end else if (busy) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                state_q <= ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= CBSU_PC_RST;
            done_q <= 1'b0;
        end else begin
            done_q <= busy && (cnt_q == 2'h1);
            if (busy && (cnt_q == 2'h1)) begin
                pc_q <= tgt_q;
            end else if (wr_fire && paddr == CBSU_PC_OFS) begin
                pc_q <= pwdata[15:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pc_o = pc_q;
    assign busy_o = busy;
    assign taken_o = taken_q;
    assign done_o = done_q;

    // ========================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_skip_on_adv: assert property (
        start && new_op == OP_SKIP_ON && io_q[new_sel] && !new_two
        |-> ##3 pc_q == $past(pc_q, 3) + 16'h0002)
        else $error("skip on set bit did not advance by two");

    a_flag_on_tgt: assert property (
        start && new_op == OP_FLAG_ON && flags_q[new_sel]
        |-> ##3 pc_q == $past(pc_q, 3)
        + {{9{$past(k_q[6], 3)}}, $past(k_q, 3)} + 16'h0001)
        else $error("branch on set flag missed target");

    a_flag_off_seq: assert property (
        start && new_op == OP_FLAG_OFF && flags_q[new_sel]
        |-> ##2 (!busy && pc_q == $past(pc_q, 2) + 16'h0001))
        else $error("branch on clear flag taken when set");

    a_zero_test: assert property (
        done_q && op_q inside {OP_EQ, OP_NE}
        |-> taken_q == (flags_q[CBSU_F_Z] == (op_q == OP_EQ)))
        else $error("zero flag branch decision wrong");

    a_carry_test: assert property (
        done_q && op_q inside {OP_CS, OP_CC}
        |-> taken_q == (flags_q[CBSU_F_C] == (op_q == OP_CS)))
        else $error("carry branch decision wrong");

    a_unsigned_test: assert property (
        done_q && op_q inside {OP_SH, OP_LO}
        |-> taken_q == (flags_q[CBSU_F_C] == (op_q == OP_LO)))
        else $error("unsigned compare branch wrong");

    a_sign_test: assert property (
        done_q && op_q inside {OP_MI, OP_PL}
        |-> taken_q == (flags_q[CBSU_F_N] == (op_q == OP_MI)))
        else $error("negative flag branch wrong");

    a_signed_ge: assert property (
        done_q && op_q == OP_GE
        |-> taken_q == !(flags_q[CBSU_F_N] ^ flags_q[CBSU_F_V]))
        else $error("signed ge decision wrong");

    a_signed_lt: assert property (
        done_q && op_q == OP_LT
        |-> taken_q == (flags_q[CBSU_F_N] ^ flags_q[CBSU_F_V]))
        else $error("signed lt decision wrong");

    a_half_test: assert property (
        done_q && op_q inside {OP_HS, OP_HC}
        |-> taken_q == (flags_q[CBSU_F_H] == (op_q == OP_HS)))
        else $error("half carry branch wrong");

    a_user_test: assert property (
        done_q && op_q inside {OP_TS, OP_TC}
        |-> taken_q == (flags_q[CBSU_F_T] == (op_q == OP_TS)))
        else $error("user bit branch wrong");

    a_ovf_test: assert property (
        done_q && op_q inside {OP_VS, OP_VC}
        |-> taken_q == (flags_q[CBSU_F_V] == (op_q == OP_VS)))
        else $error("overflow branch wrong");

    a_irq_test: assert property (
        done_q && op_q == OP_IE |-> taken_q == flags_q[CBSU_F_I])
        else $error("irq enable branch wrong");

    a_skip_off_adv: assert property (
        start && new_op == OP_SKIP_OFF && !io_q[new_sel] && new_two
        |=> busy [*3] ##1 (!busy && pc_q == $past(pc_q, 4) + 16'h0003))
        else $error("skip on clear bit did not advance by three");

    a_flags_kept: assert property (
        busy |=> $stable(flags_q))
        else $error("flags changed during branch or skip");

    a_branch_time: assert property (
        start && !op_skip(new_op) && new_cond
        |-> ##1 busy ##1 busy ##1 !busy)
        else $error("taken branch not two cycles");

    a_skip_fail: assert property (
        start && op_skip(new_op) && !new_cond
        |-> ##1 busy ##1 (!busy && pc_q == $past(pc_q, 2) + 16'h0001))
        else $error("failed skip not one cycle");

endmodule // cbsu_top

`default_nettype wire
